// ---- verilog/pmpp_consts.vh ----
// Constants of the program memory parallel port
// Summary of operation
// R01 - Three separate active-low chip selects share one address and data bus.
// R02 - Select zero is the boot flash: 16-bit bus, at most 120 ns access.
// R03 - Boot memory is a standard parallel NOR flash, single or multi-bank.
// R04 - Selects one and two serve optional peripherals with the same bus and limits.
// R05 - Full 256 Mb range needs the top address bit 23 routed out.
// R06 - Software programs wait states from the minimum up to 31.
// R07 - Read phase lasts the programmed read count of 6 ns wait steps; the code counts one mclk_i cycle of 50 ns per wait state instead.
// R08 - Select and address lead the write strobe by the setup wait count.
// R09 - Write strobe stays low for the pulse-width wait count.
// R10 - Write data is valid before the strobe rises and through the pulse.
// R11 - Select and data stay valid after the strobe rises for the hold count.
// R12 - Every phase runs at least one wait state, never zero.
// R13 - At most one select active; all strobes high when idle.
// R14 - Each chip select keeps its own wait-state settings.
`ifndef PMPP_CONSTS_VH
`define PMPP_CONSTS_VH
`define PMPP_NUM_CS 3
`define PMPP_DATA_W 16
`define PMPP_ADDR_W 24
`define PMPP_WAIT_W 5
`define PMPP_WAIT_MAX 5'h1F
`define PMPP_WAIT_MIN 5'h01
`define PMPP_WAIT_STEP_NS 6
`define PMPP_MARGIN_NS 5
`define PMPP_MAX_ACCESS_NS 120
`define PMPP_CLK_PERIOD_NS 50
`define PMPP_CS_BOOT 2'h0
`define PMPP_CS_AUX 2'h1
`define PMPP_CS_PERIPH 2'h2
`define PMPP_RST_WAIT 5'h1F
`endif

// ---- verilog/pmpp_phase_timer.v ----
// Wait-state phase counter
`timescale 1ns/100ps
`default_nettype none
`include "pmpp_consts.vh"
module pmpp_phase_timer
(
    input wire mclk_i,
    input wire sys_rst_i,
    input wire load_i,
    input wire [4:0] count_i, // R06
    output wire done_o
);
    reg [4:0] cnt_q;
    wire [4:0] cnt_d;
    // Zero loads become one so no phase ever collapses
    assign cnt_d = (count_i < `PMPP_WAIT_MIN) ? `PMPP_WAIT_MIN : count_i; // R12
    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
            cnt_q <= 5'h00;
        else if (load_i)
            cnt_q <= cnt_d;
        else if (cnt_q != 5'h00)
            cnt_q <= cnt_q - 5'h01;
    end
    // Must not look at load, which the sequencer derives from done
    assign done_o = (cnt_q == 5'h01);
endmodule // pmpp_phase_timer
`default_nettype wire

// ---- verilog/pmpp_port.v ----
// Program memory parallel port sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pmpp_consts.vh"
module pmpp_port
(
    input wire mclk_i,
    input wire sys_rst_i,
    input wire req_i,
    input wire write_i,
    input wire [1:0] cs_sel_i,
    input wire [23:0] addr_i,
    input wire [15:0] wdata_i,
    input wire top_addr_en_i,
    input wire [4:0] rd_wait_boot_i,
    input wire [4:0] rd_wait_aux_i,
    input wire [4:0] rd_wait_periph_i,
    input wire [4:0] wr_setup_wait_boot_i,
    input wire [4:0] wr_setup_wait_aux_i,
    input wire [4:0] wr_setup_wait_periph_i,
    input wire [4:0] wr_pulse_wait_boot_i,
    input wire [4:0] wr_pulse_wait_aux_i,
    input wire [4:0] wr_pulse_wait_periph_i,
    input wire [4:0] wr_hold_wait_boot_i,
    input wire [4:0] wr_hold_wait_aux_i,
    input wire [4:0] wr_hold_wait_periph_i,
    input wire [15:0] mem_data_i,
    output reg [15:0] mem_data_o,
    output reg mem_data_oe_o,
    output reg [22:0] mem_addr_o,
    output reg mem_addr_bit_top_o,
    output reg boot_mem_select_n_o,
    output reg aux_mem_select_n_o,
    output reg periph_mem_select_n_o,
    output reg mem_read_enable_n_o,
    output reg mem_write_strobe_n_o,
    output reg busy_o,
    output reg done_o,
    output reg [15:0] rdata_o,
    output reg sel_err_o
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_READ = 5'h02;
    localparam [4:0] ST_WSETUP = 5'h04;
    localparam [4:0] ST_WPULSE = 5'h08;
    localparam [4:0] ST_WHOLD = 5'h10;

    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [1:0] cs_q;
    reg load;
    reg [4:0] load_cnt;
    wire phase_done;

    // Per-select timing lookup
    function [4:0] pmpp_pick;
        input [1:0] sel;
        input [4:0] w0;
        input [4:0] w1;
        input [4:0] w2;
        begin
            case (sel)
                `PMPP_CS_BOOT: pmpp_pick = w0;
                `PMPP_CS_AUX: pmpp_pick = w1;
                default: pmpp_pick = w2;
            endcase
        end
    endfunction

    wire sel_ok = (cs_sel_i != 2'h3);
    wire start = req_i && sel_ok && (state_q == ST_IDLE);

    pmpp_phase_timer u_timer
    (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(load),
        .count_i(load_cnt),
        .done_o(phase_done)
    );

    always @*
    begin
        state_d = state_q;
        load = 1'b0;
        load_cnt = 5'h00;
        case (state_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    load = 1'b1;
                    if (write_i)
                    begin
                        state_d = ST_WSETUP;
                        load_cnt = pmpp_pick(cs_sel_i, wr_setup_wait_boot_i, wr_setup_wait_aux_i,
                            wr_setup_wait_periph_i); // R08 R14
                    end
                    else
                    begin
                        state_d = ST_READ;
                        load_cnt = pmpp_pick(cs_sel_i, rd_wait_boot_i, rd_wait_aux_i, rd_wait_periph_i); // R07 R14
                    end
                end
            end
            ST_READ:
            begin
                if (phase_done)
                    state_d = ST_IDLE;
            end
            ST_WSETUP:
            begin
                if (phase_done)
                begin
                    state_d = ST_WPULSE;
                    load = 1'b1;
                    load_cnt = pmpp_pick(cs_q, wr_pulse_wait_boot_i, wr_pulse_wait_aux_i,
                        wr_pulse_wait_periph_i); // R09 R14
                end
            end
            ST_WPULSE:
            begin
                if (phase_done)
                begin
                    state_d = ST_WHOLD;
                    load = 1'b1;
                    load_cnt = pmpp_pick(cs_q, wr_hold_wait_boot_i, wr_hold_wait_aux_i,
                        wr_hold_wait_periph_i); // R11 R14
                end
            end
            ST_WHOLD:
            begin
                if (phase_done)
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    wire active_d = (state_d != ST_IDLE);

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            cs_q <= `PMPP_CS_BOOT;
            mem_data_o <= 16'h0000;
            mem_data_oe_o <= 1'b0;
            mem_addr_o <= 23'h000000;
            mem_addr_bit_top_o <= 1'b0;
            boot_mem_select_n_o <= 1'b1;
            aux_mem_select_n_o <= 1'b1;
            periph_mem_select_n_o <= 1'b1;
            mem_read_enable_n_o <= 1'b1;
            mem_write_strobe_n_o <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            sel_err_o <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_o <= 1'b0;
            sel_err_o <= req_i && !sel_ok && (state_q == ST_IDLE);
            if (start)
            begin
                cs_q <= cs_sel_i;
                mem_addr_o <= addr_i[22:0];
                mem_addr_bit_top_o <= top_addr_en_i & addr_i[23]; // R05
                mem_data_o <= wdata_i;
            end
            // Only one select follows the latched choice
            boot_mem_select_n_o <= !(active_d && ((start ? cs_sel_i : cs_q) == `PMPP_CS_BOOT)); // R01 R02 R13
            aux_mem_select_n_o <= !(active_d && ((start ? cs_sel_i : cs_q) == `PMPP_CS_AUX)); // R01 R04 R13
            periph_mem_select_n_o <= !(active_d && ((start ? cs_sel_i : cs_q) == `PMPP_CS_PERIPH)); // R01 R04 R13
            mem_read_enable_n_o <= !(state_d == ST_READ); // R07 R13
            mem_write_strobe_n_o <= !(state_d == ST_WPULSE); // R09 R13
            // Data driven from setup through hold covers both edges of the strobe
            mem_data_oe_o <= (state_d == ST_WSETUP) || (state_d == ST_WPULSE) || (state_d == ST_WHOLD); // R10 R11
            busy_o <= active_d;
            if ((state_q == ST_READ) && phase_done)
            begin
                rdata_o <= mem_data_i;
                done_o <= 1'b1;
            end
            if ((state_q == ST_WHOLD) && phase_done)
                done_o <= 1'b1;
        end
    end
endmodule // pmpp_port
`default_nettype wire

// ---- tb/pmpp_port_asserts.sv ----
// Protocol checks on the program memory port pins
`timescale 1ns/100ps
`default_nettype none
module pmpp_port_asserts
(
    input wire mclk_i,
    input wire sys_rst_i,
    input wire req_i,
    input wire [1:0] cs_sel_i,
    input wire boot_mem_select_n_o,
    input wire aux_mem_select_n_o,
    input wire periph_mem_select_n_o,
    input wire mem_read_enable_n_o,
    input wire mem_write_strobe_n_o,
    input wire mem_data_oe_o,
    input wire busy_o,
    input wire done_o,
    input wire sel_err_o
);
    wire [2:0] sel_n = {periph_mem_select_n_o, aux_mem_select_n_o, boot_mem_select_n_o};
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_take; req_i && !busy_o && cs_sel_i != 2'h3; endsequence
    sequence s_pulse; $fell(mem_write_strobe_n_o); endsequence
    property p_one; $countones(~sel_n) <= 1; endproperty
    property p_idle; !busy_o |-> sel_n == 3'h7 && mem_read_enable_n_o && mem_write_strobe_n_o; endproperty
    property p_take; s_take |=> busy_o && sel_n != 3'h7; endproperty
    property p_bad; req_i && !busy_o && cs_sel_i == 2'h3 |=> sel_err_o && sel_n == 3'h7; endproperty
    property p_setup; s_pulse |-> $past(sel_n) != 3'h7 && $past(mem_data_oe_o); endproperty
    property p_data; !mem_write_strobe_n_o |-> mem_data_oe_o && sel_n != 3'h7; endproperty
    property p_hold; $rose(mem_write_strobe_n_o) |-> sel_n != 3'h7 && mem_data_oe_o && !done_o; endproperty
    property p_rd_end; $rose(mem_read_enable_n_o) |-> done_o && !busy_o; endproperty
    a_one: assert property (p_one) else $error("two selects low");
    a_idle: assert property (p_idle) else $error("strobe low while idle");
    a_take: assert property (p_take) else $error("access not started");
    a_bad: assert property (p_bad) else $error("bad select not refused");
    a_setup: assert property (p_setup) else $error("no setup before strobe");
    a_data: assert property (p_data) else $error("data not driven in pulse");
    a_hold: assert property (p_hold) else $error("no hold after strobe");
    a_rd_end: assert property (p_rd_end) else $error("read end without done");
endmodule // pmpp_port_asserts
`default_nettype wire

// ---- tb/pmpp_flash_model.sv ----
// Flash and peripheral model on the parallel port
`timescale 1ns/100ps
`default_nettype none
module pmpp_flash_model
(
    input wire mclk_i,
    input wire [2:0] sel_n_i,
    input wire read_en_n_i,
    input wire [22:0] addr_i,
    output logic [15:0] data_o
);
    logic [15:0] junk_q = 16'h0000;
    // Released bus toggles so a late sample never matches
    always @(posedge mclk_i)
        junk_q <= ~junk_q;
    assign data_o = (!read_en_n_i && sel_n_i != 3'h7) ? addr_i[15:0] ^ {13'h0, ~sel_n_i} ^ 16'h3C5A : junk_q;
endmodule // pmpp_flash_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the program memory port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, req_i = 1'b0, write_i = 1'b0, top_addr_en_i = 1'b0;
    logic [1:0] cs_sel_i = 2'h0;
    logic [23:0] addr_i = 24'h000000;
    logic [15:0] wdata_i = 16'h0000;
    logic [4:0] rd[3] = '{5'h00, 5'h1F, 5'h03}, su[3] = '{5'h01, 5'h00, 5'h02};
    logic [4:0] pw[3] = '{5'h02, 5'h05, 5'h00}, ho[3] = '{5'h00, 5'h03, 5'h01};
    wire [15:0] mem_data_i, mem_data_o, rdata_o;
    wire [22:0] mem_addr_o;
    wire mem_data_oe_o, mem_addr_bit_top_o, boot_mem_select_n_o, aux_mem_select_n_o, periph_mem_select_n_o;
    wire mem_read_enable_n_o, mem_write_strobe_n_o, busy_o, done_o, sel_err_o;
    wire [2:0] sel_n = {periph_mem_select_n_o, aux_mem_select_n_o, boot_mem_select_n_o};
    int num_errors = 0, checks_done = 0, n[4];
    pmpp_port DUT
    (
        .mclk_i, .sys_rst_i, .req_i, .write_i, .cs_sel_i, .addr_i, .wdata_i, .top_addr_en_i,
        .rd_wait_boot_i(rd[0]), .rd_wait_aux_i(rd[1]), .rd_wait_periph_i(rd[2]),
        .wr_setup_wait_boot_i(su[0]), .wr_setup_wait_aux_i(su[1]), .wr_setup_wait_periph_i(su[2]),
        .wr_pulse_wait_boot_i(pw[0]), .wr_pulse_wait_aux_i(pw[1]), .wr_pulse_wait_periph_i(pw[2]),
        .wr_hold_wait_boot_i(ho[0]), .wr_hold_wait_aux_i(ho[1]), .wr_hold_wait_periph_i(ho[2]),
        .mem_data_i, .mem_data_o, .mem_data_oe_o, .mem_addr_o, .mem_addr_bit_top_o, .boot_mem_select_n_o,
        .aux_mem_select_n_o, .periph_mem_select_n_o, .mem_read_enable_n_o, .mem_write_strobe_n_o,
        .busy_o, .done_o, .rdata_o, .sel_err_o
    );
    pmpp_flash_model u_mem (.mclk_i, .sel_n_i(sel_n), .read_en_n_i(mem_read_enable_n_o), .addr_i(mem_addr_o),
        .data_o(mem_data_i));
    initial forever #25 mclk_i = ~mclk_i;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic int mx1(input logic [4:0] x);
        return (x == 5'h00) ? 1 : x;
    endfunction
    // Counts read enable low, strobe low, setup and selected cycles up to done
    task automatic run(input logic w, input int cs, input logic [23:0] a);
        @(posedge mclk_i);
        req_i <= 1'b1; write_i <= w; cs_sel_i <= cs[1:0]; addr_i <= a; wdata_i <= ~a[15:0];
        @(posedge mclk_i);
        req_i <= 1'b0;
        n = '{0, 0, 0, 0};
        repeat (80)
        begin
            @(negedge mclk_i);
            if (done_o === 1'b1)
                break;
            n[0] += !mem_read_enable_n_o;
            n[1] += !mem_write_strobe_n_o;
            n[2] += (n[1] == 0 && sel_n != 3'h7);
            n[3] += (sel_n == ~(3'h1 << cs));
            if (!mem_write_strobe_n_o)
                chk({mem_data_oe_o, mem_data_o}, {1'b1, ~a[15:0]});
        end
        chk(done_o, 1'b1);
        chk({sel_n, mem_addr_bit_top_o, mem_addr_o}, {3'h7, a[23] & top_addr_en_i, a[22:0]});
    endtask
    task automatic t_read();
        for (int cs = 0; cs < 3; cs++)
        begin
            @(posedge mclk_i);
            top_addr_en_i <= cs[0];
            run(1'b0, cs, 24'h8A5A50 + cs);
            chk(n[0], mx1(rd[cs]));
            chk(n[3], mx1(rd[cs]));
            chk(rdata_o, (16'h5A50 + cs) ^ (16'h1 << cs) ^ 16'h3C5A);
        end
    endtask
    task automatic t_write();
        for (int cs = 0; cs < 3; cs++)
        begin
            run(1'b1, cs, 24'h0F0F00 + cs);
            chk(n[2], mx1(su[cs]));
            chk(n[1], mx1(pw[cs]));
            chk(n[3] - n[2] - n[1], mx1(ho[cs]));
        end
    endtask
    task automatic t_bad();
        @(posedge mclk_i);
        req_i <= 1'b1; cs_sel_i <= 2'h3;
        @(posedge mclk_i);
        req_i <= 1'b0;
        @(negedge mclk_i);
        chk({sel_err_o, busy_o, sel_n}, {2'b10, 3'h7});
    endtask
    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_read();
        t_write();
        t_bad();
        complete_run();
    end
    initial
    begin
        #100000;
        num_errors++;
        complete_run();
    end
endmodule // testbench
bind pmpp_port pmpp_port_asserts u_chk (.mclk_i, .sys_rst_i, .req_i, .cs_sel_i, .boot_mem_select_n_o,
    .aux_mem_select_n_o, .periph_mem_select_n_o, .mem_read_enable_n_o, .mem_write_strobe_n_o, .mem_data_oe_o,
    .busy_o, .done_o, .sel_err_o);
`default_nettype wire
